// >>> lspi_top.sv
// Legacy byte-at-a-time serial master with AXI4-Lite registers
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module lspi_top
    import lspi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe_n,
    output logic irq
);
    lspi_shift_if sif ();

    // AXI write capture, write response and read response state
    logic aw_ok_q;
    logic w_ok_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Software registers
    logic event_q;
    logic irq_en_q;
    logic [ENABLE_W-1:0] enable_q;
    logic [31:0] sck_sel_q;
    logic [31:0] out_sel_q;
    logic [31:0] in_sel_q;
    logic [31:0] rate_q;
    logic [2:0] format_q;
    logic [7:0] tx_last_q;

    // Transmit queue of two bytes
    logic [7:0] txm_q [2];
    logic txw_q;
    logic txr_q;
    logic [1:0] txc_q;

    // Receive path: visible byte and second stage
    logic [7:0] rxd_q;
    logic rxd_full_q;
    logic [7:0] rx2_q;
    logic rx2_full_q;

    logic [PIN_COUNT-1:0] pin_sync;
    logic [PIN_COUNT-1:0] out_d;
    logic [PIN_COUNT-1:0] oe_n_d;
    logic irq_q;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        wmerge = r;
    endfunction

    function automatic logic [9:0] rate_half(input logic [31:0] code);
        logic [9:0] h;
        h = HALF_BASE >> 1;
        for (int i = 0; i < RATE_CODES; i++)
        begin
            if (code == (RATE_MIN_CODE << i))
            begin
                h = HALF_BASE >> i;
            end
        end
        rate_half = h;
    endfunction

    function automatic logic known(input logic [ADDR_W-1:0] a);
        known = (a == OFF_EVENT) || (a == OFF_IRQ_SET) || (a == OFF_IRQ_CLR) ||
                (a == OFF_ENABLE) || (a == OFF_SCK_SEL) || (a == OFF_OUT_SEL) ||
                (a == OFF_IN_SEL) || (a == OFF_RX) || (a == OFF_TX) ||
                (a == OFF_RATE) || (a == OFF_FORMAT);
    endfunction

    // Decode
    wire unit_on = (enable_q == ENABLE_ON);
    wire wr_go = aw_ok_q && w_ok_q && !bvalid_q;
    wire [ADDR_W-1:0] wa = {aw_addr_q[ADDR_W-1:2], 2'b00};
    wire [ADDR_W-1:0] ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
    wire rd_go = s_axi_arvalid && !rvalid_q;
    wire wr_ok = wr_go && known(wa);
    wire wr_event = wr_ok && (wa == OFF_EVENT) && w_strb_q[0];
    wire wr_irq_set = wr_ok && (wa == OFF_IRQ_SET) && w_strb_q[0] && w_data_q[0];
    wire wr_irq_clr = wr_ok && (wa == OFF_IRQ_CLR) && w_strb_q[0] && w_data_q[0];
    wire wr_tx = wr_ok && (wa == OFF_TX) && w_strb_q[0];
    wire rd_rx = rd_go && (ra == OFF_RX);
    wire tx_take = sif.start;
    wire tx_push = wr_tx && (txc_q != 2'h2);
    wire rx_done = sif.done;
    wire rx_move = rd_rx && rx2_full_q;
    wire sck_hit_any = unit_on && !sck_sel_q[PSEL_CONNECT_BIT];
    wire out_hit_any = unit_on && !out_sel_q[PSEL_CONNECT_BIT];
    wire in_hit = unit_on && !in_sel_q[PSEL_CONNECT_BIT];
    wire [31:0] enable_merge = wmerge({28'h0, enable_q}, w_data_q, w_strb_q);
    wire [31:0] format_merge = wmerge({29'h0, format_q}, w_data_q, w_strb_q);
    wire [PIN_W-1:0] in_pin = in_sel_q[PIN_W-1:0];

    assign s_axi_awready = !aw_ok_q;
    assign s_axi_wready = !w_ok_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign irq = irq_q;

    // Shifter controls
    assign sif.start = unit_on && !sif.busy && !sif.done && (txc_q != 2'h0);
    assign sif.tx_byte = txm_q[txr_q];
    assign sif.pol = format_q[FMT_POL_BIT];
    assign sif.pha = format_q[FMT_PHASE_BIT];
    assign sif.lsb_first = format_q[FMT_ORDER_BIT];
    assign sif.half_cnt = rate_half(rate_q);
    assign sif.din = in_hit ? pin_sync[in_pin] : 1'b0;

    lspi_sync #(
        .W(PIN_COUNT)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(pin_in),
        .q(pin_sync)
    );

    lspi_shifter u_shifter (
        .aclk(aclk),
        .aresetn(aresetn),
        .sif(sif.eng)
    );

    // Pin routing
    always_comb
    begin
        for (int p = 0; p < PIN_COUNT; p++)
        begin
            if (sck_hit_any && sck_sel_q[PIN_W-1:0] == PIN_W'(p))
            begin
                out_d[p] = sif.sck;
                oe_n_d[p] = 1'b0;
            end
            else if (out_hit_any && out_sel_q[PIN_W-1:0] == PIN_W'(p))
            begin
                out_d[p] = sif.dout;
                oe_n_d[p] = 1'b0;
            end
            else
            begin
                out_d[p] = 1'b0;
                oe_n_d[p] = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pin_out <= '0;
            pin_oe_n <= '1;
            irq_q <= 1'b0;
        end
        else
        begin
            pin_out <= out_d;
            pin_oe_n <= oe_n_d;
            irq_q <= event_q && irq_en_q;
        end
    end

    // AXI write channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ok_q <= 1'b0;
            w_ok_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && !aw_ok_q)
            begin
                aw_ok_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_ok_q)
            begin
                w_ok_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= known(wa) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
        end
        else if (rd_go)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= known(ra) ? RESP_OKAY : RESP_SLVERR;
            case (ra)
                OFF_EVENT: rdata_q <= {31'h0, event_q};
                OFF_IRQ_SET: rdata_q <= {31'h0, irq_en_q};
                OFF_IRQ_CLR: rdata_q <= {31'h0, irq_en_q};
                OFF_ENABLE: rdata_q <= {28'h0, enable_q};
                OFF_SCK_SEL: rdata_q <= sck_sel_q;
                OFF_OUT_SEL: rdata_q <= out_sel_q;
                OFF_IN_SEL: rdata_q <= in_sel_q;
                OFF_RX: rdata_q <= {24'h0, rxd_q};
                OFF_TX: rdata_q <= {24'h0, tx_last_q};
                OFF_RATE: rdata_q <= rate_q;
                OFF_FORMAT: rdata_q <= {29'h0, format_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq_en_q <= 1'b0;
            enable_q <= RST_ZERO[ENABLE_W-1:0];
            sck_sel_q <= RST_PSEL;
            out_sel_q <= RST_PSEL;
            in_sel_q <= RST_PSEL;
            rate_q <= RST_RATE;
            format_q <= RST_ZERO[2:0];
            tx_last_q <= 8'h00;
        end
        else
        begin
            if (wr_irq_set)
            begin
                irq_en_q <= 1'b1;
            end
            else if (wr_irq_clr)
            begin
                irq_en_q <= 1'b0;
            end
            if (wr_ok && wa == OFF_ENABLE)
            begin
                enable_q <= enable_merge[ENABLE_W-1:0];
            end
            if (wr_ok && wa == OFF_SCK_SEL)
            begin
                sck_sel_q <= wmerge(sck_sel_q, w_data_q, w_strb_q);
            end
            if (wr_ok && wa == OFF_OUT_SEL)
            begin
                out_sel_q <= wmerge(out_sel_q, w_data_q, w_strb_q);
            end
            if (wr_ok && wa == OFF_IN_SEL)
            begin
                in_sel_q <= wmerge(in_sel_q, w_data_q, w_strb_q);
            end
            if (wr_ok && wa == OFF_RATE)
            begin
                rate_q <= wmerge(rate_q, w_data_q, w_strb_q);
            end
            if (wr_ok && wa == OFF_FORMAT)
            begin
                format_q <= format_merge[2:0];
            end
            if (wr_tx)
            begin
                tx_last_q <= w_data_q[7:0];
            end
        end
    end

    // Transmit queue, written in order and drained in order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            txm_q[0] <= 8'h00;
            txm_q[1] <= 8'h00;
            txw_q <= 1'b0;
            txr_q <= 1'b0;
            txc_q <= 2'h0;
        end
        else
        begin
            if (tx_push)
            begin
                txm_q[txw_q] <= w_data_q[7:0];
                txw_q <= !txw_q;
            end
            if (tx_take)
            begin
                txr_q <= !txr_q;
            end
            if (tx_push && !tx_take)
            begin
                txc_q <= txc_q + 2'h1;
            end
            else if (tx_take && !tx_push)
            begin
                txc_q <= txc_q - 2'h1;
            end
        end
    end

    // Receive stages and byte-done event
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rxd_q <= 8'h00;
            rxd_full_q <= 1'b0;
            rx2_q <= 8'h00;
            rx2_full_q <= 1'b0;
            event_q <= 1'b0;
        end
        else
        begin
            if (rx_move)
            begin
                rxd_q <= rx2_q;
                rx2_full_q <= 1'b0;
            end
            else if (rd_rx)
            begin
                rxd_full_q <= 1'b0;
            end
            if (rx_done)
            begin
                if (!rxd_full_q || (rd_rx && !rx2_full_q))
                begin
                    rxd_q <= sif.rx_byte;
                    rxd_full_q <= 1'b1;
                end
                else
                begin
                    rx2_q <= sif.rx_byte;
                    rx2_full_q <= 1'b1;
                end
            end
            // Hardware set wins over a software clear in the same cycle
            if (rx_move || (rx_done && (!rxd_full_q || (rd_rx && !rx2_full_q))))
            begin
                event_q <= 1'b1;
            end
            else if (wr_event)
            begin
                event_q <= w_data_q[0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> lspi_pkg.sv
// Constants, register map and types shared by the serial master block
package lspi_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_EVENT = 12'h108;
    localparam logic [11:0] OFF_IRQ_SET = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
    localparam logic [11:0] OFF_ENABLE = 12'h500;
    localparam logic [11:0] OFF_SCK_SEL = 12'h508;
    localparam logic [11:0] OFF_OUT_SEL = 12'h50c;
    localparam logic [11:0] OFF_IN_SEL = 12'h510;
    localparam logic [11:0] OFF_RX = 12'h518;
    localparam logic [11:0] OFF_TX = 12'h51c;
    localparam logic [11:0] OFF_RATE = 12'h524;
    localparam logic [11:0] OFF_FORMAT = 12'h554;

    localparam logic [31:0] RST_ZERO = 32'h00000000;
    localparam logic [31:0] RST_PSEL = 32'hffffffff;
    localparam logic [31:0] RST_RATE = 32'h04000000;
    localparam logic [31:0] RATE_MIN_CODE = 32'h02000000;
    localparam int RATE_CODES = 7;

    localparam int PIN_W = 5;
    localparam int PIN_COUNT = 32;
    localparam int PSEL_CONNECT_BIT = 31;
    localparam int FMT_ORDER_BIT = 0;
    localparam int FMT_PHASE_BIT = 1;
    localparam int FMT_POL_BIT = 2;
    localparam int ENABLE_W = 4;
    localparam logic [3:0] ENABLE_ON = 4'h1;

    localparam int CLK_HZ = 250_000_000;
    localparam int RATE_BASE_BPS = 125_000;
    localparam logic [9:0] HALF_BASE = 10'(CLK_HZ / (2 * RATE_BASE_BPS));
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;
    localparam int TAIL_NS = 20;
    localparam logic [9:0] TAIL_CYC = 10'((TAIL_NS * CLK_MHZ + 999) / 1000);
    localparam logic [4:0] LAST_EDGE = 5'h0f;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_RUN = 2'b01,
        ENG_TAIL = 2'b10
    } lspi_eng_state_t;
endpackage

// >>> lspi_shift_if.sv
// Signals between the register front end and the byte shifter
`timescale 1ns/1ps
`default_nettype none
interface lspi_shift_if;
    logic start;
    logic busy;
    logic done;
    logic [7:0] tx_byte;
    logic [7:0] rx_byte;
    logic pol;
    logic pha;
    logic lsb_first;
    logic [9:0] half_cnt;
    logic din;
    logic sck;
    logic dout;
    modport eng (input start, tx_byte, pol, pha, lsb_first, half_cnt, din,
                 output busy, done, rx_byte, sck, dout);
    modport ctl (output start, tx_byte, pol, pha, lsb_first, half_cnt, din,
                 input busy, done, rx_byte, sck, dout);
endinterface
`default_nettype wire

// >>> lspi_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module lspi_sync #(
    parameter int W = 32
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_q <= '0;
            q <= '0;
        end
        else
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule
`default_nettype wire

// >>> lspi_shifter.sv
// Byte shifter: serial clock generation, data out and data in
`timescale 1ns/1ps
`default_nettype none
module lspi_shifter
    import lspi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    lspi_shift_if.eng sif
);
    lspi_eng_state_t state_q;
    logic [9:0] div_q;
    logic [4:0] edge_q;
    logic [2:0] out_n_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic sck_q;
    logic dout_q;
    logic done_q;
    logic [7:0] rx_byte_q;

    wire leading = !edge_q[0];
    wire half_up = (div_q == sif.half_cnt - 10'h001);
    wire do_sample = half_up && (leading != sif.pha);
    wire do_drive = half_up && ((leading && sif.pha) || (!leading && !sif.pha && edge_q != LAST_EDGE));

    function automatic logic pick(input logic [7:0] b, input logic [2:0] n, input logic lsb);
        pick = lsb ? b[n] : b[3'h7 - n];
    endfunction

    assign sif.busy = (state_q != ENG_IDLE);
    assign sif.sck = sck_q;
    assign sif.dout = dout_q;
    assign sif.done = done_q;
    assign sif.rx_byte = rx_byte_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= ENG_IDLE;
            div_q <= 10'h000;
            edge_q <= 5'h00;
            out_n_q <= 3'h0;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            sck_q <= 1'b0;
            dout_q <= 1'b0;
            done_q <= 1'b0;
            rx_byte_q <= 8'h00;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                ENG_IDLE:
                begin
                    sck_q <= sif.pol;
                    div_q <= 10'h000;
                    edge_q <= 5'h00;
                    dout_q <= 1'b0;
                    if (sif.start)
                    begin
                        tx_q <= sif.tx_byte;
                        state_q <= ENG_RUN;
                        // Leading-edge sampling needs the first bit out now
                        if (!sif.pha)
                        begin
                            dout_q <= pick(sif.tx_byte, 3'h0, sif.lsb_first);
                            out_n_q <= 3'h1;
                        end
                        else
                        begin
                            out_n_q <= 3'h0;
                        end
                    end
                end
                ENG_RUN:
                begin
                    if (half_up)
                    begin
                        div_q <= 10'h000;
                        sck_q <= !sck_q;
                        edge_q <= edge_q + 5'h01;
                        if (edge_q == LAST_EDGE)
                        begin
                            state_q <= ENG_TAIL;
                        end
                    end
                    else
                    begin
                        div_q <= div_q + 10'h001;
                    end
                    if (do_sample)
                    begin
                        rx_q <= sif.lsb_first ? {sif.din, rx_q[7:1]} : {rx_q[6:0], sif.din};
                    end
                    if (do_drive)
                    begin
                        dout_q <= pick(tx_q, out_n_q, sif.lsb_first);
                        out_n_q <= out_n_q + 3'h1;
                    end
                end
                ENG_TAIL:
                begin
                    if (div_q == TAIL_CYC - 10'h001)
                    begin
                        rx_byte_q <= rx_q;
                        done_q <= 1'b1;
                        state_q <= ENG_IDLE;
                    end
                    else
                    begin
                        div_q <= div_q + 10'h001;
                    end
                end
                default:
                begin
                    state_q <= ENG_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> lspi_sva.sv
// Bus and interrupt assertions for the serial master
`timescale 1ns/1ps
`default_nettype none
module lspi_sva
    import lspi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence aw_take;
        s_axi_awvalid && s_axi_awready;
    endsequence
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer:
        assert property (aw_take |-> ##[1:4] s_axi_bvalid) else $error("write unanswered");
    a_write_refuse:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("w taken");
    a_bvalid_holds:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b dropped");
    a_read_answer:
        assert property (ar_take |=> s_axi_rvalid) else $error("read unanswered");
    a_read_refuse:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar taken");
    a_rdata_holds:
        assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata)) else $error("r moved");
    a_unmapped_read:
        assert property (ar_take ##0 (s_axi_araddr == 12'h000) |=> s_axi_rresp == RESP_SLVERR
            && s_axi_rdata == 32'h0) else $error("unmapped read");
    a_irq_cleared:
        assert property (aw_take ##0 (s_axi_awaddr == OFF_IRQ_CLR && s_axi_wvalid && s_axi_wready
            && s_axi_wdata[0]) |-> ##[1:4] !irq) else $error("irq stays");
endmodule
bind lspi_top lspi_sva lspi_sva_i (.*);
`default_nettype wire

// >>> lspi_slave_model.sv
// Serial slave answering each byte with the previous byte xor a5, the first byte after reset with 99 xor a5
`timescale 1ns/1ps
`default_nettype none
module lspi_slave_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic sck,
    input wire logic mosi,
    input wire logic act,
    input wire logic [2:0] cfg,
    output logic miso,
    output logic [7:0] got,
    output logic stb
);
    logic s_q;
    logic [3:0] lead_q, trail_q;
    logic [7:0] sh_q, last_q, nsh, rep;
    logic [2:0] di;
    wire lead_e = act && s_q == cfg[2] && sck != cfg[2];
    wire trail_e = act && s_q != cfg[2] && sck == cfg[2];
    wire samp = cfg[1] ? trail_e : lead_e;
    assign di = cfg[1] ? 3'(lead_q - 4'h1) : trail_q[2:0];
    assign rep = last_q ^ 8'ha5;
    assign miso = rep[cfg[0] ? di : 3'h7 - di];
    assign nsh = cfg[0] ? {mosi, sh_q[7:1]} : {sh_q[6:0], mosi};
    // No chip select: byte framing by clock count, with the counts cleared while act is low
    always_ff @(posedge aclk)
    begin
        s_q <= act ? sck : cfg[2];
        stb <= 1'h0;
        if (samp) sh_q <= nsh;
        if (lead_e) lead_q <= lead_q + 4'h1;
        if (trail_e) trail_q <= trail_q + 4'h1;
        if (trail_e && trail_q == 4'h7)
        begin
            got <= cfg[1] ? nsh : sh_q;
            last_q <= cfg[1] ? nsh : sh_q;
            stb <= 1'h1;
            {lead_q, trail_q} <= '0;
        end
        if (!act) {lead_q, trail_q} <= '0;
        if (!aresetn) last_q <= 8'h99;
    end
endmodule
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the serial master
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lspi_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic irq, miso, stb;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [2:0] s_axi_awprot, s_axi_arprot, cfg;
    logic [31:0] s_axi_wdata, s_axi_rdata, pin_in, pin_out, pin_oe_n, noise, rnd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] got, b0, b1, last;
    logic [7:0] mq[$];
    int bad_count, checks_done;
    assign pin_in = {noise[31:6], miso, noise[4:0]} & pin_oe_n | pin_out & ~pin_oe_n;
    lspi_top lspi_top_i (.*);
    lspi_slave_model lspi_slave_model_i (.aclk, .aresetn, .sck(pin_out[3]), .mosi(pin_out[4]),
        .act(~pin_oe_n[3]), .cfg, .miso, .got, .stb);
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    initial
    begin
        aclk = 0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk)
    begin
        rnd <= xs(rnd);
        noise <= rnd;
    end
    always @(negedge aclk)
    begin
        if (stb === 1'h1) ck("mosi", mq.pop_front(), got);
    end
    task automatic ck(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        logic aw, w, b;
        logic [1:0] rs;
        {aw, w, b, rs} = 5'h00;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!b)
        begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            {b, rs} = {s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
        end
        s_axi_bready <= 1'h0;
        ck("bresp", r, rs);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
        logic ar, v;
        logic [31:0] rdat;
        logic [1:0] rs;
        {ar, v, rdat, rs} = 36'h0;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        while (!v)
        begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            {v, rdat, rs} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'h0;
        end
        s_axi_rready <= 1'h0;
        ck("rdata", e, rdat);
        ck("rresp", r, rs);
    endtask
    initial
    begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, cfg} = '0;
        {s_axi_wstrb, rnd, noise, last} = {4'hf, 32'h00003681, 32'h0, 8'h99};
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        ck("oe", 32'hffffffff, pin_oe_n);
        rd(OFF_EVENT, 32'h0);
        rd(OFF_SCK_SEL, RST_PSEL);
        rd(OFF_RATE, RST_RATE);
        rd(12'h000, 32'h0, RESP_SLVERR);
        wr(12'h000, 32'h0, RESP_SLVERR);
        wr(OFF_SCK_SEL, 32'h3);
        wr(OFF_OUT_SEL, 32'h4);
        wr(OFF_IN_SEL, 32'h5);
        wr(OFF_RATE, 32'h80000000);
        wr(OFF_IRQ_SET, 32'h1);
        $display("registers done");
        for (int m = 0; m < 8; m++)
        begin
            cfg <= 3'(m);
            wr(OFF_ENABLE, 32'h0);
            wr(OFF_FORMAT, 32'(m));
            wr(OFF_ENABLE, 32'h1);
            {b1, b0} = rnd[15:0];
            mq.push_back(b0);
            mq.push_back(b1);
            wr(OFF_TX, {24'h0, b0});
            wr(OFF_TX, {24'h0, b1});
            while (irq !== 1'h1) @(posedge aclk);
            repeat (600) @(posedge aclk);
            ck("sck pin", {cfg[2], 2'h0}, {pin_out[3], pin_oe_n[3], pin_out[4]});
            wr(OFF_EVENT, 32'h0);
            rd(OFF_EVENT, 32'h0);
            rd(OFF_RX, {24'h0, last ^ 8'ha5});
            rd(OFF_EVENT, 32'h1);
            rd(OFF_RX, {24'h0, b0 ^ 8'ha5});
            wr(OFF_EVENT, 32'h0);
            last = b1;
            $display("mode %0d done", m);
        end
        wr(OFF_EVENT, 32'h1);
        repeat (2) @(posedge aclk);
        ck("irq on", 32'h1, irq);
        wr(OFF_IRQ_CLR, 32'h1);
        rd(OFF_IRQ_SET, 32'h0);
        ck("irq off", 32'h0, irq);
        wr(OFF_ENABLE, 32'h0);
        rd(OFF_EVENT, 32'h1);
        ck("oe off", 32'hffffffff, pin_oe_n);
        results();
    end
    initial
    begin
        repeat (40000) @(posedge aclk);
        bad_count++;
        $display("watchdog expired");
        results();
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
endmodule
`default_nettype wire
